// ==== pcs_pkg.sv ====
package pcs_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int SYS_CLK_PERIOD_NS = 10;
  // Lock time after a dynamic delay change; plain default, tune per part.
  localparam int LOCK_TIME_NS = 20000;
  localparam int LOCK_HOLD_CYCLES = (LOCK_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int FINE_STEP_PS = 125;
  localparam int FINE_STEP_RAW = FINE_STEP_PS / (SYS_CLK_PERIOD_NS * 1000);
  localparam int FINE_STEP_CYCLES = (FINE_STEP_RAW < 1) ? 1 : FINE_STEP_RAW;
  localparam int FINE_MAX_STEPS = 16;
  // 22.5 degree steps make sixteen coarse steps per output period.
  localparam int COARSE_STEPS_PER_CYCLE = 16;
  localparam int LOCK_GOOD_COUNT = 4;

  // ==========================================================================
  // Sizes
  // ==========================================================================
  localparam int RATIO_W = 8;
  localparam int NUM_PRIMARY = 8;
  localparam int NUM_SECONDARY = 8;
  localparam int NUM_REGIONS = 20;
  localparam int SLICES_WITH_REGS = 3;
  localparam int NUM_CLOCK_PINS = 6;
  localparam int NUM_EDGE_CLOCKS = 6;
  localparam int NUM_ROUTE = 8;
  localparam int PRI_SEL_W = 4;
  localparam int CLK_SEL_W = 5;
  localparam int CTRL_SEL_W = 3;
  localparam int EDGE_SEL_W = 3;
  localparam int FINE_W = 5;
  localparam int COARSE_W = 4;
  localparam int TAP_DEPTH = 256;
  localparam int TAP_W = 8;

  // ==========================================================================
  // Encodings and reset values
  // ==========================================================================
  localparam logic [CLK_SEL_W-1:0] SEL_NONE = 5'h00;
  localparam logic [RATIO_W-1:0] OSC_HALF_RESET = 8'h08;
  localparam logic [RATIO_W-1:0] OSC_HALF_MIN = 8'h01;
  localparam logic [RATIO_W-1:0] OSC_HALF_MAX = 8'hFF;
  localparam int PIN_TOP0 = 0;
  localparam int PIN_TOP1 = 1;
  localparam int PIN_LEFT0 = 2;
  localparam int PIN_LEFT1 = 3;
  localparam int PIN_RIGHT0 = 4;
  localparam int PIN_RIGHT1 = 5;
  localparam int EDGE_TOP0 = 0;
  localparam int EDGE_LEFT0 = 2;
  localparam int EDGE_RIGHT0 = 4;

  typedef enum logic [2:0] {
    PCS_LOOP_ACQUIRE = 3'b001,
    PCS_LOOP_LOCKED  = 3'b010,
    PCS_LOOP_HOLDOFF = 3'b100
  } pcs_loop_state_type;

endpackage

// ==== pcs_divider.sv ====
`timescale 1ns/10ps
module pcs_divider
  import pcs_pkg::*;
(
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_tick,
  input  wire logic [RATIO_W-1:0] i_ratio,
  output logic o_pulse,
  output logic o_level
);

  logic [RATIO_W-1:0] count_ff;
  logic last;

  // A ratio of zero behaves as one so the divider never stalls.
  assign last = (i_ratio <= 8'h01) || (count_ff >= i_ratio - 8'h01);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      count_ff <= 8'h00;
      o_pulse <= 1'b0;
      o_level <= 1'b0;
    end else begin
      o_pulse <= i_tick && last;
      if (i_tick) begin
        count_ff <= last ? 8'h00 : count_ff + 8'h01;
        if (last) begin
          o_level <= ~o_level;
        end
      end
    end
  end

endmodule

// ==== pcs_tap_delay.sv ====
`timescale 1ns/10ps
module pcs_tap_delay
  import pcs_pkg::*;
#(
  parameter int DEPTH = TAP_DEPTH
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_data,
  input  wire logic [TAP_W-1:0] i_tap_a,
  input  wire logic [TAP_W-1:0] i_tap_b,
  output logic o_tap_a,
  output logic o_tap_b
);

  logic [DEPTH-1:0] hist_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      hist_ff <= '0;
      o_tap_a <= 1'b0;
      o_tap_b <= 1'b0;
    end else begin
      hist_ff <= {hist_ff[DEPTH-2:0], i_data};
      o_tap_a <= hist_ff[i_tap_a];
      o_tap_b <= hist_ff[i_tap_b];
    end
  end

endmodule

// ==== pcs_clock_fabric.sv ====
// Operation
// - Reference passes input divider, feedback passes feedback divider; feedback ratio multiplies.
// - Lock output rises once the oscillator tracks the divided reference.
// - Dynamic delay change drops lock; no relock before the lock time elapses.
// - Oscillator feeds a primary divider so it runs faster than primary output.
// - Secondary dividers take primary or shifted output and make slower outputs.
// - Phase and duty of shifted output come from static setting or fabric.
// - Fine delay inserts zero to sixteen 125 ps steps on the shifted output in dynamic mode (each step takes one 10 ns cycle); the static count is not clamped.
// - Coarse phase shifts both edges of shifted output in 22.5 degree steps.
// - Primary, both divided and shifted outputs all reach the distribution network.
// - Network offers eight quadrant primary clocks and eight secondary sources.
// - Six dedicated clock pins: two each top, left and right.
// - Region mux has eight sources: first four control, last four clock.
// - Last source also serves control; first three also serve clocks.
// - Twenty regions, each with eight secondary resources for clock or control.
// - Slice clock mux gets all primaries, seven secondaries and a routed signal.
// - Slice clock or control mux with nothing selected outputs logic one.
// - Only slices zero to two carry clock and control muxes.
// - Each edge clock is driven from same-edge pins, loops and delay loops; only left and right ones also from dividers.
// - Six edge clocks; left and right muxes get distinct loop outputs.
// - Both delay loops and top-left/top-right loops can also drive top edge clocks.
// - Slave delay-line clock reaches every left and right edge clock mux.
`timescale 1ns/10ps
module pcs_clock_fabric
  import pcs_pkg::*;
#(
  parameter int LOCK_HOLD = LOCK_HOLD_CYCLES,
  parameter logic [FINE_W-1:0] STATIC_FINE = 5'h00,
  parameter logic [COARSE_W-1:0] STATIC_COARSE = 4'h0,
  parameter logic [COARSE_W-1:0] STATIC_DUTY = 4'h0
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  input  wire logic i_ref_clock_in,
  input  wire logic i_ref_route,
  input  wire logic i_ref_use_route,
  input  wire logic i_feedback_clock,
  input  wire logic [NUM_CLOCK_PINS-1:0] i_clock_pins,
  input  wire logic [1:0] i_dll_out,
  input  wire logic i_delay_line_clock,
  input  wire logic [1:0] i_clock_divider_block,
  input  wire logic [1:0] i_loop_top,
  input  wire logic [NUM_ROUTE-1:0] i_route,
  input  wire logic [RATIO_W-1:0] i_in_div,
  input  wire logic [RATIO_W-1:0] i_fb_div,
  input  wire logic [RATIO_W-1:0] i_prim_div,
  input  wire logic [RATIO_W-1:0] i_sec_div,
  input  wire logic [RATIO_W-1:0] i_sec_div_b,
  input  wire logic i_sec_src_shifted,
  input  wire logic i_dyn_mode,
  input  wire logic [FINE_W-1:0] i_fine_steps,
  input  wire logic [COARSE_W-1:0] i_coarse_steps,
  input  wire logic [COARSE_W-1:0] i_duty_steps,
  input  wire logic [NUM_PRIMARY*PRI_SEL_W-1:0] i_primary_sel,
  input  wire logic [NUM_SECONDARY*PRI_SEL_W-1:0] i_secondary_sel,
  input  wire logic [NUM_REGIONS*SLICES_WITH_REGS*CLK_SEL_W-1:0] i_slice_clk_sel,
  input  wire logic [NUM_REGIONS*SLICES_WITH_REGS*CTRL_SEL_W-1:0] i_slice_ctrl_sel,
  input  wire logic [NUM_EDGE_CLOCKS*EDGE_SEL_W-1:0] i_edge_sel,
  output logic o_lock,
  output logic o_primary_loop_out,
  output logic o_shifted_loop_out,
  output logic o_divided_loop_out,
  output logic o_divided_loop_out_b,
  output logic [NUM_PRIMARY-1:0] o_primary_clocks,
  output logic [NUM_SECONDARY-1:0] o_secondary_sources,
  output logic [NUM_REGIONS*NUM_SECONDARY-1:0] o_region_secondary,
  output logic [NUM_REGIONS*SLICES_WITH_REGS-1:0] o_slice_clock,
  output logic [NUM_REGIONS*SLICES_WITH_REGS-1:0] o_slice_ctrl,
  output logic [NUM_EDGE_CLOCKS-1:0] o_edge_clocks
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Select code zero means nothing is chosen; the output then idles high.
  function automatic logic pick_or_one(input logic [15:0] src, input logic [CLK_SEL_W-1:0] sel);
    logic [3:0] idx;
    idx = 4'(sel - 5'h01);
    if (sel == SEL_NONE || sel > 5'h10) begin
      pick_or_one = 1'b1;
    end else begin
      pick_or_one = src[idx];
    end
  endfunction

  // Coarse offset is steps times period over sixteen, clamped to the delay line.
  function automatic logic [TAP_W-1:0] shift_tap(input logic [RATIO_W-1:0] half_osc,
                                                 input logic [RATIO_W-1:0] prim,
                                                 input logic [COARSE_W-1:0] coarse,
                                                 input logic [FINE_W-1:0] fine);
    logic [31:0] period;
    logic [31:0] total;
    period = 32'(half_osc) * 32'((prim == 8'h00) ? 8'h01 : prim) * 32'd2;
    total = (32'(coarse) * period) / 32'(COARSE_STEPS_PER_CYCLE) + 32'(fine) * 32'(FINE_STEP_CYCLES);
    shift_tap = (total > 32'(TAP_DEPTH - 1)) ? TAP_W'(TAP_DEPTH - 1) : total[TAP_W-1:0];
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int NSYNC = NUM_CLOCK_PINS + 9;
  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] pins_raw;

  assign pins_raw = {i_loop_top, i_clock_divider_block, i_delay_line_clock, i_dll_out,
                     i_feedback_clock, i_ref_clock_in, i_clock_pins};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= pins_raw;
      sync2_ff <= sync1_ff;
    end
  end

  logic [NUM_CLOCK_PINS-1:0] pin_s;
  logic ref_pin_s;
  logic fb_s;
  logic [1:0] dll_s;
  logic delay_line_s;
  logic [1:0] clock_divider_block_s;
  logic [1:0] loop_top_s;

  assign pin_s = sync2_ff[NUM_CLOCK_PINS-1:0];
  assign ref_pin_s = sync2_ff[NUM_CLOCK_PINS];
  assign fb_s = sync2_ff[NUM_CLOCK_PINS+1];
  assign dll_s = sync2_ff[NUM_CLOCK_PINS+3:NUM_CLOCK_PINS+2];
  assign delay_line_s = sync2_ff[NUM_CLOCK_PINS+4];
  assign clock_divider_block_s = sync2_ff[NUM_CLOCK_PINS+6:NUM_CLOCK_PINS+5];
  assign loop_top_s = sync2_ff[NUM_CLOCK_PINS+8:NUM_CLOCK_PINS+7];

  // ==========================================================================
  // Input and feedback dividers
  // ==========================================================================
  logic ref_sel;
  logic ref_d_ff;
  logic fb_d_ff;
  logic ref_div_pulse;
  logic fb_div_pulse;

  assign ref_sel = i_ref_use_route ? i_ref_route : ref_pin_s;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ref_d_ff <= 1'b0;
      fb_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_sel;
      fb_d_ff <= fb_s;
    end
  end

  pcs_divider u_in_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(ref_sel && !ref_d_ff),
    .i_ratio(i_in_div),
    .o_pulse(ref_div_pulse),
    .o_level()
  );

  pcs_divider u_fb_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(fb_s && !fb_d_ff),
    .i_ratio(i_fb_div),
    .o_pulse(fb_div_pulse),
    .o_level()
  );

  // ==========================================================================
  // Detector and oscillator
  // ==========================================================================
  // Feedback ticks per divided reference tick steer the oscillator period:
  // none means too slow, more than one means too fast.
  logic [1:0] fb_seen_ff;
  logic [RATIO_W-1:0] osc_half_ff;
  logic [RATIO_W-1:0] osc_cnt_ff;
  logic osc_tick_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fb_seen_ff <= 2'h0;
    end else if (ref_div_pulse) begin
      fb_seen_ff <= {1'b0, fb_div_pulse};
    end else if (fb_div_pulse && fb_seen_ff != 2'h2) begin
      fb_seen_ff <= fb_seen_ff + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      osc_half_ff <= OSC_HALF_RESET;
    end else if (ref_div_pulse) begin
      if (fb_seen_ff == 2'h0 && osc_half_ff > OSC_HALF_MIN) begin
        osc_half_ff <= osc_half_ff - 8'h01;
      end else if (fb_seen_ff == 2'h2 && osc_half_ff < OSC_HALF_MAX) begin
        osc_half_ff <= osc_half_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      osc_cnt_ff <= 8'h00;
      osc_tick_ff <= 1'b0;
    end else begin
      osc_tick_ff <= (osc_cnt_ff + 8'h01 >= osc_half_ff);
      osc_cnt_ff <= (osc_cnt_ff + 8'h01 >= osc_half_ff) ? 8'h00 : osc_cnt_ff + 8'h01;
    end
  end

  // ==========================================================================
  // Phase and duty settings
  // ==========================================================================
  logic [FINE_W-1:0] fine_eff;
  logic [COARSE_W-1:0] coarse_eff;
  logic [COARSE_W-1:0] duty_eff;
  logic [FINE_W-1:0] fine_ff;
  logic [COARSE_W-1:0] coarse_ff;
  logic [COARSE_W-1:0] duty_ff;
  logic delay_change;

  // Dynamic fine counts above sixteen are clamped; the static setting is not.
  assign fine_eff = i_dyn_mode ? ((i_fine_steps > 5'(FINE_MAX_STEPS)) ? 5'(FINE_MAX_STEPS) : i_fine_steps)
                               : STATIC_FINE;
  assign coarse_eff = i_dyn_mode ? i_coarse_steps : STATIC_COARSE;
  assign duty_eff = i_dyn_mode ? i_duty_steps : STATIC_DUTY;
  assign delay_change = i_dyn_mode && (fine_eff != fine_ff || coarse_eff != coarse_ff || duty_eff != duty_ff);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      fine_ff <= 5'h00;
      coarse_ff <= 4'h0;
      duty_ff <= 4'h0;
    end else begin
      fine_ff <= fine_eff;
      coarse_ff <= coarse_eff;
      duty_ff <= duty_eff;
    end
  end

  // ==========================================================================
  // Lock tracking
  // ==========================================================================
  pcs_loop_state_type state_ff;
  logic [2:0] good_ff;
  logic [31:0] hold_ff;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_ff <= PCS_LOOP_ACQUIRE;
      good_ff <= 3'h0;
      hold_ff <= 32'h0;
    end else if (delay_change) begin
      state_ff <= PCS_LOOP_HOLDOFF;
      good_ff <= 3'h0;
      hold_ff <= 32'(LOCK_HOLD);
    end else begin
      unique case (state_ff)
        PCS_LOOP_ACQUIRE: begin
          if (ref_div_pulse) begin
            good_ff <= (fb_seen_ff == 2'h1) ? good_ff + 3'h1 : 3'h0;
            if (fb_seen_ff == 2'h1 && good_ff + 3'h1 >= 3'(LOCK_GOOD_COUNT)) begin
              state_ff <= PCS_LOOP_LOCKED;
            end
          end
        end
        PCS_LOOP_LOCKED: begin
          if (ref_div_pulse && fb_seen_ff != 2'h1) begin
            state_ff <= PCS_LOOP_ACQUIRE;
            good_ff <= 3'h0;
          end
        end
        PCS_LOOP_HOLDOFF: begin
          if (hold_ff <= 32'h1) begin
            state_ff <= PCS_LOOP_ACQUIRE;
            hold_ff <= 32'h0;
          end else begin
            hold_ff <= hold_ff - 32'h1;
          end
        end
        default: begin
          state_ff <= PCS_LOOP_ACQUIRE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_lock <= 1'b0;
    end else begin
      o_lock <= (state_ff == PCS_LOOP_LOCKED) && !delay_change;
    end
  end

  // ==========================================================================
  // Output dividers and phase shift
  // ==========================================================================
  logic prim_level;
  logic tap_a;
  logic tap_b;
  logic shifted;
  logic shifted_d_ff;
  logic sec_src;
  logic sec_d_ff;
  logic div_a_level;
  logic div_b_level;
  logic [TAP_W-1:0] tap_a_idx_ff;
  logic [TAP_W-1:0] tap_b_idx_ff;

  pcs_divider u_prim_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(osc_tick_ff),
    .i_ratio(i_prim_div),
    .o_pulse(),
    .o_level(prim_level)
  );

  // Duty trim widens the high time by delaying the falling edge.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tap_a_idx_ff <= 8'h00;
      tap_b_idx_ff <= 8'h00;
    end else begin
      tap_a_idx_ff <= shift_tap(osc_half_ff, i_prim_div, coarse_ff, fine_ff);
      tap_b_idx_ff <= shift_tap(osc_half_ff, i_prim_div, 4'(coarse_ff + duty_ff), fine_ff);
    end
  end

  pcs_tap_delay u_shift (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_data(prim_level),
    .i_tap_a(tap_a_idx_ff),
    .i_tap_b(tap_b_idx_ff),
    .o_tap_a(tap_a),
    .o_tap_b(tap_b)
  );

  assign shifted = tap_a | tap_b;
  assign sec_src = i_sec_src_shifted ? shifted : prim_level;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sec_d_ff <= 1'b0;
      shifted_d_ff <= 1'b0;
    end else begin
      sec_d_ff <= sec_src;
      shifted_d_ff <= shifted;
    end
  end

  pcs_divider u_sec_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(sec_src && !sec_d_ff),
    .i_ratio(i_sec_div),
    .o_pulse(),
    .o_level(div_a_level)
  );

  pcs_divider u_sec_div_b (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_tick(sec_src && !sec_d_ff),
    .i_ratio(i_sec_div_b),
    .o_pulse(),
    .o_level(div_b_level)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_primary_loop_out <= 1'b0;
      o_shifted_loop_out <= 1'b0;
      o_divided_loop_out <= 1'b0;
      o_divided_loop_out_b <= 1'b0;
    end else begin
      o_primary_loop_out <= prim_level;
      o_shifted_loop_out <= shifted_d_ff;
      o_divided_loop_out <= div_a_level;
      o_divided_loop_out_b <= div_b_level;
    end
  end

  // ==========================================================================
  // Primary and secondary sources
  // ==========================================================================
  // Selects are static configuration; a change while running may glitch.
  logic [3:0] loop_outs;
  logic [15:0] pri_src;
  logic [15:0] sec_src_vec;

  assign loop_outs = {div_b_level, div_a_level, shifted_d_ff, prim_level};
  assign pri_src = {i_route[1:0], clock_divider_block_s, dll_s, loop_outs, pin_s};
  assign sec_src_vec = {i_route[5:0], loop_outs, pin_s};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_primary_clocks <= '0;
      o_secondary_sources <= '0;
    end else begin
      for (int q = 0; q < NUM_PRIMARY; q++) begin
        o_primary_clocks[q] <= pri_src[i_primary_sel[q*PRI_SEL_W +: PRI_SEL_W]];
      end
      for (int s = 0; s < NUM_SECONDARY; s++) begin
        o_secondary_sources[s] <= sec_src_vec[i_secondary_sel[s*PRI_SEL_W +: PRI_SEL_W]];
      end
    end
  end

  // ==========================================================================
  // Region and slice selection
  // ==========================================================================
  logic [15:0] slice_clk_src;
  logic [15:0] slice_ctrl_src;

  // Secondary indices 0-2 join the clock side; index 7 joins the control side.
  assign slice_clk_src = {i_route[6], o_secondary_sources[7:4], o_secondary_sources[2:0],
                          o_primary_clocks};
  assign slice_ctrl_src = {10'h000, i_route[7], o_secondary_sources[7], o_secondary_sources[3:0]};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_region_secondary <= '0;
      o_slice_clock <= '1;
      o_slice_ctrl <= '1;
    end else begin
      for (int r = 0; r < NUM_REGIONS; r++) begin
        o_region_secondary[r*NUM_SECONDARY +: NUM_SECONDARY] <= o_secondary_sources;
        for (int k = 0; k < SLICES_WITH_REGS; k++) begin
          o_slice_clock[r*SLICES_WITH_REGS+k] <= pick_or_one(slice_clk_src,
            i_slice_clk_sel[(r*SLICES_WITH_REGS+k)*CLK_SEL_W +: CLK_SEL_W]);
          o_slice_ctrl[r*SLICES_WITH_REGS+k] <= pick_or_one(slice_ctrl_src,
            {2'b00, i_slice_ctrl_sel[(r*SLICES_WITH_REGS+k)*CTRL_SEL_W +: CTRL_SEL_W]});
        end
      end
    end
  end

  // ==========================================================================
  // Edge clocks
  // ==========================================================================
  logic [7:0] edge_top_src;
  logic [7:0] edge_left_src;
  logic [7:0] edge_right_src;

  assign edge_top_src = {1'b0, i_route[0], loop_top_s, dll_s, pin_s[PIN_TOP1], pin_s[PIN_TOP0]};
  assign edge_left_src = {i_route[1], clock_divider_block_s[0], delay_line_s, dll_s[0], shifted_d_ff, prim_level,
                          pin_s[PIN_LEFT1], pin_s[PIN_LEFT0]};
  assign edge_right_src = {i_route[2], clock_divider_block_s[1], delay_line_s, dll_s[1], div_b_level, div_a_level,
                           pin_s[PIN_RIGHT1], pin_s[PIN_RIGHT0]};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_edge_clocks <= '0;
    end else begin
      for (int e = 0; e < 2; e++) begin
        o_edge_clocks[EDGE_TOP0+e] <= edge_top_src[i_edge_sel[(EDGE_TOP0+e)*EDGE_SEL_W +: EDGE_SEL_W]];
        o_edge_clocks[EDGE_LEFT0+e] <= edge_left_src[i_edge_sel[(EDGE_LEFT0+e)*EDGE_SEL_W +: EDGE_SEL_W]];
        o_edge_clocks[EDGE_RIGHT0+e] <= edge_right_src[i_edge_sel[(EDGE_RIGHT0+e)*EDGE_SEL_W +: EDGE_SEL_W]];
      end
    end
  end

endmodule

// ==== pcs_clock_fabric_assertions.sv ====
`timescale 1ns/10ps
module pcs_chk
  import pcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [NUM_CLOCK_PINS-1:0] i_clock_pins,
  input wire logic [1:0] i_dll_out,
  input wire logic i_delay_line_clock,
  input wire logic i_dyn_mode,
  input wire logic [COARSE_W-1:0] i_coarse_steps,
  input wire logic [NUM_REGIONS*SLICES_WITH_REGS*CLK_SEL_W-1:0] i_slice_clk_sel,
  input wire logic [NUM_REGIONS*SLICES_WITH_REGS*CTRL_SEL_W-1:0] i_slice_ctrl_sel,
  input wire logic [NUM_EDGE_CLOCKS*EDGE_SEL_W-1:0] i_edge_sel,
  input wire logic o_lock,
  input wire logic [NUM_PRIMARY-1:0] o_primary_clocks,
  input wire logic [NUM_REGIONS*SLICES_WITH_REGS-1:0] o_slice_clock,
  input wire logic [NUM_REGIONS*SLICES_WITH_REGS-1:0] o_slice_ctrl,
  input wire logic [NUM_EDGE_CLOCKS-1:0] o_edge_clocks
);
  // ======
  // Checks
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  a_slice_idle_one: assert property ((i_slice_clk_sel[9:5] == 5'h00)[*2] |-> o_slice_clock[1])
    else $error("idle slice clock low");
  a_ctrl_idle_one: assert property ((i_slice_ctrl_sel[2:0] == 3'h0)[*2] |-> o_slice_ctrl[0])
    else $error("idle slice control low");
  a_slice_clk_follow: assert property ((i_slice_clk_sel[4:0] == 5'h01)[*3] |-> o_slice_clock[0] == $past(o_primary_clocks[0]))
    else $error("slice clock not primary");
  a_lock_drop: assert property (i_dyn_mode && $stable(i_dyn_mode) && $changed(i_coarse_steps) |-> ##[1:2] !o_lock)
    else $error("lock kept after change");
  a_relock_wait: assert property (i_dyn_mode && $stable(i_dyn_mode) && $changed(i_coarse_steps) |-> ##2 (!o_lock)[*8])
    else $error("early relock");
  a_edge_pin_path: assert property ((i_edge_sel[2:0] == 3'h0)[*5] |-> o_edge_clocks[0] == $past(i_clock_pins[0], 3))
    else $error("top edge not pin");
  a_edge_dll_top: assert property ((i_edge_sel[5:3] == 3'h2)[*5] |-> o_edge_clocks[1] == $past(i_dll_out[0], 3))
    else $error("top edge not dll");
  a_edge_delay_line: assert property ((i_edge_sel[8:6] == 3'h5)[*5] |-> o_edge_clocks[2] == $past(i_delay_line_clock, 3))
    else $error("left edge not delay line");
endmodule

bind pcs_clock_fabric pcs_chk i_pcs_chk (.*);

// ==== pcs_partner.sv ====
`timescale 1ns/10ps
module pcs_partner (
  input wire logic i_clk_sys,
  input wire logic i_loop_out,
  output logic o_ref_clock_in,
  output logic o_feedback_clock
);
  // ======
  // Reference pin and board feedback path
  logic [4:0] cnt_ff = 5'h00;
  logic fb_ff = 1'b0;
  // The board trace adds a register of delay, so lock must tolerate feedback phase.
  always_ff @(posedge i_clk_sys) begin
    cnt_ff <= cnt_ff + 5'h01;
    fb_ff <= i_loop_out;
  end
  assign o_ref_clock_in = cnt_ff[4];
  assign o_feedback_clock = fb_ff;
endmodule

// ==== pcs_clock_fabric_test.sv ====
`timescale 1ns/10ps
module pcs_clock_fabric_test;
  logic i_clk_sys, i_rst, i_ref_clock_in, i_ref_route, i_ref_use_route, i_feedback_clock;
  logic i_delay_line_clock, i_sec_src_shifted, i_dyn_mode, o_lock;
  logic o_primary_loop_out, o_shifted_loop_out, o_divided_loop_out, o_divided_loop_out_b;
  logic [5:0] i_clock_pins, o_edge_clocks;
  logic [1:0] i_dll_out, i_clock_divider_block, i_loop_top;
  logic [7:0] i_route, i_in_div, i_fb_div, i_prim_div, i_sec_div, i_sec_div_b;
  logic [7:0] o_primary_clocks, o_secondary_sources;
  logic [4:0] i_fine_steps;
  logic [3:0] i_coarse_steps, i_duty_steps;
  logic [31:0] i_primary_sel, i_secondary_sel, rnd;
  logic [299:0] i_slice_clk_sel;
  logic [179:0] i_slice_ctrl_sel;
  logic [17:0] i_edge_sel;
  logic [159:0] o_region_secondary;
  logic [59:0] o_slice_clock, o_slice_ctrl;
  int error_cnt, checked;
  localparam int HOLD = 300;
  pcs_clock_fabric #(.LOCK_HOLD(HOLD)) i_pcs_clock_fabric (.*);
  pcs_partner i_pcs_partner (.i_clk_sys, .i_loop_out(o_primary_loop_out), .o_ref_clock_in(i_ref_clock_in),
    .o_feedback_clock(i_feedback_clock));
  // ======
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string msg);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_lock(output int n);
    n = 0;
    while (o_lock !== 1'b1) begin
      @(negedge i_clk_sys);
      n++;
      if (n > 5000) begin
        chk(0, 1, "lock timeout");
        give_verdict;
      end
    end
  endtask
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    rnd <= lfsr(rnd);
    {i_ref_route, i_route, i_loop_top, i_clock_divider_block, i_delay_line_clock, i_dll_out, i_clock_pins} <= rnd[21:0];
  end
  // ======
  // Sequence
  initial begin
    int n, c0, c1, c2;
    logic [2:0] p;
    logic [2:0] v;
    logic [63:0] h;
    logic [7:0] s;
    rnd = 32'h16240179;
    {i_ref_route, i_route, i_loop_top, i_clock_divider_block, i_delay_line_clock, i_dll_out, i_clock_pins} = 22'h0;
    error_cnt = 0;
    checked = 0;
    i_rst = 1'b1;
    {i_ref_use_route, i_sec_src_shifted, i_dyn_mode} = 3'h1;
    {i_in_div, i_fb_div, i_prim_div, i_sec_div, i_sec_div_b} = 40'h0101020102;
    {i_fine_steps, i_coarse_steps, i_duty_steps} = 13'h0;
    i_primary_sel = {rnd[27:0], 4'h6};
    i_secondary_sel = ~rnd;
    i_slice_clk_sel = 300'h01;
    i_slice_ctrl_sel = 180'h0;
    i_edge_sel = 18'h00150;
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    @(negedge i_clk_sys);
    chk({o_lock, o_edge_clocks}, 0, "reset outputs");
    chk(o_slice_ctrl & o_slice_clock, {60{1'b1}}, "reset slice");
    $display("test reset done");
    wait_lock(n);
    chk(o_lock, 1, "lock");
    // A first lock may land one oscillator step off; let the loop settle and relock.
    repeat (600) @(negedge i_clk_sys);
    wait_lock(n);
    {c0, c1, c2} = 0;
    p = {o_divided_loop_out_b, o_divided_loop_out, o_primary_loop_out};
    s = o_secondary_sources;
    // A 640-cycle window spans whole periods, so edge counts are exact.
    repeat (640) begin
      @(negedge i_clk_sys);
      v = {o_divided_loop_out_b, o_divided_loop_out, o_primary_loop_out};
      chk(o_primary_clocks[0], v[0], "primary clock 0");
      chk(o_region_secondary[159:152], s, "region copy");
      s = o_secondary_sources;
      c0 += int'(v[0] & ~p[0]);
      c1 += int'(v[1] & ~p[1]);
      c2 += int'(v[2] & ~p[2]);
      p = v;
    end
    chk(c0, 640 / 32, "primary rate");
    chk(c1, 640 / 64, "divided rate");
    chk(c2, 640 / 128, "divided b rate");
    chk(o_slice_clock[59:1], {59{1'b1}}, "idle slices");
    $display("test lock and rates done");
    @(posedge i_clk_sys);
    i_coarse_steps <= 4'h4;
    repeat (3) @(negedge i_clk_sys);
    chk(o_lock, 0, "lock after step");
    wait_lock(n);
    chk(n + 3 > HOLD, 1, "relock delay");
    n = 0;
    repeat (64) begin
      @(negedge i_clk_sys);
      h = {h[62:0], o_primary_loop_out};
      n++;
      // Four 22.5 degree steps of a 32-cycle period lag by 8, plus 3 pipeline stages.
      if (n > 12) chk(o_shifted_loop_out, h[32 * 4 / 16 + 3], "shifted phase");
    end
    $display("test dynamic step done");
    give_verdict;
  end
endmodule
